// File: frc_pkg.sv
// Shared constants, opcodes and types for the flash register command handler
package frc_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 50;

    // Self-timed write durations (status_write_time, nonvolatile_config_write_time)
    localparam int STATUS_WRITE_TIME_NS           = 1000000;
    localparam int NONVOLATILE_CONFIG_WRITE_TIME_NS = 2000000;
    localparam int STATUS_WRITE_CYCLES =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVCR_WRITE_CYCLES =
        (NONVOLATILE_CONFIG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 24;

    // Opcodes
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_CLFS  = 8'h50;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_RDFS  = 8'h70;
    localparam logic [7:0] OP_RDNV  = 8'hb5;
    localparam logic [7:0] OP_RDVC  = 8'h85;
    localparam logic [7:0] OP_RDEV  = 8'h65;
    localparam logic [7:0] OP_RDEA  = 8'hc8;
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_WRNV  = 8'hb1;
    localparam logic [7:0] OP_WRVC  = 8'h81;
    localparam logic [7:0] OP_WREV  = 8'h61;
    localparam logic [7:0] OP_WREA  = 8'hc5;

    // Bit counts within a frame
    localparam logic [4:0] OPC_BITS   = 5'h08;
    localparam logic [4:0] BYTE1_BITS = 5'h10;
    localparam logic [4:0] BYTE2_BITS = 5'h18;

    // Bit positions
    localparam int SR_WIP_BIT   = 0;
    localparam int SR_WEL_BIT   = 1;
    localparam int SR_SRWD_BIT  = 7;
    localparam int FS_PROT_BIT  = 1;
    localparam int FS_PROG_BIT  = 4;
    localparam int FS_ERASE_BIT = 5;
    localparam int FS_READY_BIT = 7;

    // Reset values and reserved masks
    localparam logic [5:0]  SR_RESET       = 6'h00;
    localparam logic [7:0]  FLAG_RESET     = 8'h00;
    localparam logic [15:0] NVCR_RESET     = 16'hffff;
    localparam logic [7:0]  VCR_RESET      = 8'h00;
    localparam logic [7:0]  EVCR_RESET     = 8'h00;
    localparam logic [7:0]  EAR_RESET      = 8'h00;
    localparam logic [15:0] NVCR_RSVD_MASK = 16'h0010;
    localparam logic [7:0]  VCR_RSVD_MASK  = 8'h04;
    localparam logic [7:0]  EVCR_RSVD_MASK = 8'h08;
    localparam logic [7:0]  EAR_RSVD_MASK  = 8'h00;

    typedef enum logic [1:0] {
        FRC_EXT  = 2'b00,
        FRC_DUAL = 2'b01,
        FRC_QUAD = 2'b10
    } frc_proto_t;

    typedef enum logic [2:0] {
        FRC_IDLE    = 3'b000,
        FRC_OPC     = 3'b001,
        FRC_WDATA   = 3'b010,
        FRC_RDATA   = 3'b011,
        FRC_ARMED   = 3'b100,
        FRC_DISCARD = 3'b101
    } frc_fsm_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  flag;
        logic [15:0] nvcr;
        logic [7:0]  vcr;
        logic [7:0]  evcr;
        logic [7:0]  ear;
    } frc_regs_t;

    typedef struct packed {
        frc_fsm_t    fsm;
        logic [7:0]  cmd;
        logic [23:0] rx;
        logic [4:0]  ibit;
        logic [7:0]  ob;
        logic [2:0]  obit;
        logic [1:0]  bidx;
        logic [3:0]  dq_out;
        logic [3:0]  dq_oe;
        logic        sck_prev;
        logic        wel;
        logic        wip;
        logic [5:0]  status;
        logic [7:0]  flag;
        logic [15:0] nvcr;
        logic [7:0]  vcr;
        logic [7:0]  evcr;
        logic [7:0]  ear;
        logic        pend_nv;
        logic        pend_ok;
        logic [15:0] pend_dat;
        logic        tmr_start;
    } frc_state_t;

endpackage

// File: frc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module frc_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } frc_sync_st_t;

    frc_sync_st_t st_q;
    frc_sync_st_t st_d;

    always_comb
    begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule // frc_sync

// File: frc_timer.sv
// Down counter for self-timed register writes
`timescale 1ns/1ps
module frc_timer
    import frc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [TMR_W-1:0] load,
    output logic                  done
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             run;
        logic             done;
    } frc_tmr_st_t;

    frc_tmr_st_t st_q;
    frc_tmr_st_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (start)
        begin
            st_d.cnt = load;
            st_d.run = 1'b1;
        end
        else if (st_q.run)
        begin
            // Never shorter than one cycle, even for a zero load
            if (st_q.cnt <= 1)
            begin
                st_d.run  = 1'b0;
                st_d.done = 1'b1;
            end
            else
                st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign done = st_q.done;
endmodule // frc_timer

// File: frc_cmd.sv
// Register command handler: write latch, register reads and writes over SPI lanes
// How it works
// RULE1 - Host raises select right after opcode
// RULE2 - Opcode on one, two or four lanes
// RULE3 - Extra clocks after enable/disable discard command
// RULE4 - Opcode 06h sets write latch
// RULE5 - Opcode 04h clears latch unless protection error
// RULE6 - Protection error keeps latch; clear-flag clears both
// RULE7 - Extended reads out on lane 1
// RULE8 - Read ends whenever select rises
// RULE9 - Status and flag reads always served
// RULE10 - Config read 16 bits, then zeros
// RULE11 - Config read low byte first
// RULE12 - Other register reads repeat one byte
// RULE13 - Host sets write latch before writes
// RULE14 - Host raises select after last data bit
// RULE15 - Late select rise drops write, latch kept
// RULE16 - Status and nonvolatile config writes are self-timed
// RULE17 - Status write touches bits 7:2 only
// RULE18 - Protect bit with pin gives hardware lock
// RULE19 - Busy during timed write; end clears both
// RULE20 - Volatile writes immediate, reserved bits kept
// RULE21 - Host sends config payload low byte first
// RULE22 - Protected target sets flags 1,4, keeps latch
// RULE23 - Clear-flag resets error flag bits
// RULE24 - Sample MSB first on rise, ignore unknowns
`timescale 1ns/1ps
module frc_cmd
    import frc_pkg::*;
#(
    parameter int TW_CYCLES    = STATUS_WRITE_CYCLES,
    parameter int NONVOLATILE_CONFIG_WRITE_TIME_CYCLES = NVCR_WRITE_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic [3:0] dq_in,
    input  wire logic       wp_n,
    input  wire frc_proto_t proto_sel,
    input  wire logic       array_busy,
    input  wire logic       prog_fail_evt,
    input  wire logic       erase_fail_evt,
    input  wire logic       prot_fail_evt,
    output logic      [3:0] dq_out,
    output logic      [3:0] dq_oe,
    output logic            wel,
    output logic            wip,
    output frc_regs_t       regs
);
    frc_state_t st_q;
    frc_state_t st_d;
    logic [6:0] pins_s;
    logic       sck_s;
    logic       cs_n_s;
    logic       cs_s;
    logic [3:0] dq_s;
    logic       wp_n_s;
    logic       tmr_done;
    logic       sck_rise;
    logic       sck_fall;
    logic       exec;
    logic [7:0] rd_byte;
    logic [7:0] sr_view;
    logic [7:0] fs_view;
    logic [15:0] nv_view;

    frc_sync #(.W(7)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      ({wp_n, dq_in, !cs_n, sck}),
        .dout     (pins_s)
    );
    // Select synced as active high so reset reads as deselected
    assign {wp_n_s, dq_s, cs_s, sck_s} = pins_s;
    assign cs_n_s = !cs_s;

    frc_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (st_q.tmr_start),
        .load     (st_q.pend_nv ? TMR_W'(NONVOLATILE_CONFIG_WRITE_TIME_CYCLES) : TMR_W'(TW_CYCLES)),
        .done     (tmr_done)
    );

    function automatic logic [2:0] lane_width(frc_proto_t p);
        case (p)
            FRC_DUAL: lane_width = 3'h2;
            FRC_QUAD: lane_width = 3'h4;
            default:  lane_width = 3'h1;
        endcase
    endfunction

    // Masked update keeps reserved bits
    function automatic logic [7:0] keep_rsvd(logic [7:0] old_v, logic [7:0] new_v, logic [7:0] m);
        keep_rsvd = (new_v & ~m) | (old_v & m);
    endfunction

    assign sck_rise = sck_s && !st_q.sck_prev;
    assign sck_fall = !sck_s && st_q.sck_prev;
    assign exec     = (st_q.fsm == FRC_ARMED) && cs_n_s;

    // RULE9 - live status view
    assign sr_view = {st_q.status, st_q.wel, st_q.wip};
    assign fs_view = {!(st_q.wip || array_busy), st_q.flag[6:0]};
    // RULE10 - reserved read high
    assign nv_view = st_q.nvcr | NVCR_RSVD_MASK;

    always_comb
    begin
        case (st_q.cmd)
            OP_RDSR: rd_byte = sr_view;
            OP_RDFS: rd_byte = fs_view;
            // RULE11 - low byte first
            OP_RDNV: rd_byte = (st_q.bidx == 2'h0) ? nv_view[7:0] :
                               (st_q.bidx == 2'h1) ? nv_view[15:8] : 8'h00;
            // RULE12 - same byte repeats
            OP_RDVC: rd_byte = st_q.vcr;
            OP_RDEV: rd_byte = st_q.evcr;
            OP_RDEA: rd_byte = st_q.ear;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        logic [23:0] rx_n;
        logic [4:0]  ib_n;
        logic [7:0]  bv;
        logic [2:0]  ob_n;
        rx_n = '0;
        ib_n = '0;
        bv   = '0;
        ob_n = '0;
        st_d           = st_q;
        st_d.sck_prev  = sck_s;
        st_d.tmr_start = 1'b0;

        // RULE2 - lanes per protocol
        // RULE24 - MSB first on rising edge
        case (proto_sel)
            FRC_DUAL: rx_n = {st_q.rx[21:0], dq_s[1:0]};
            FRC_QUAD: rx_n = {st_q.rx[19:0], dq_s};
            default:  rx_n = {st_q.rx[22:0], dq_s[0]};
        endcase
        ib_n = st_q.ibit + {2'b00, lane_width(proto_sel)};

        if (st_q.fsm == FRC_IDLE)
        begin
            if (!cs_n_s)
            begin
                st_d.fsm  = FRC_OPC;
                st_d.ibit = '0;
                st_d.rx   = '0;
            end
        end
        else if (cs_n_s)
        begin
            // RULE8 - select rise ends any frame
            st_d.fsm    = FRC_IDLE;
            st_d.dq_oe  = 4'h0;
            st_d.dq_out = 4'h0;
            if (exec)
            begin
                case (st_q.cmd)
                    // RULE4 - set latch
                    OP_WREN: st_d.wel = 1'b1;
                    // RULE5 - clear latch unless error
                    // RULE6 - error pending keeps latch
                    OP_WRDI: st_d.wel = st_q.flag[FS_PROT_BIT];
                    // RULE23 - clear error flags
                    OP_CLFS:
                    begin
                        st_d.flag[FS_PROT_BIT]  = 1'b0;
                        st_d.flag[FS_PROG_BIT]  = 1'b0;
                        st_d.flag[FS_ERASE_BIT] = 1'b0;
                        st_d.wel                = 1'b0;
                    end
                    // RULE16 - start timed write
                    // RULE19 - busy while timed
                    OP_WRSR:
                    begin
                        st_d.wip       = 1'b1;
                        st_d.pend_nv   = 1'b0;
                        st_d.pend_dat  = {8'h00, st_q.rx[7:0]};
                        // RULE18 - protect bit with pin
                        st_d.pend_ok   = !(st_q.status[SR_SRWD_BIT-2] && !wp_n_s);
                        st_d.tmr_start = 1'b1;
                    end
                    // RULE21 - low byte arrived first
                    OP_WRNV:
                    begin
                        st_d.wip       = 1'b1;
                        st_d.pend_nv   = 1'b1;
                        st_d.pend_dat  = {st_q.rx[7:0], st_q.rx[15:8]};
                        st_d.pend_ok   = 1'b1;
                        st_d.tmr_start = 1'b1;
                    end
                    // RULE20 - immediate, reserved kept
                    OP_WRVC:
                    begin
                        st_d.vcr = keep_rsvd(st_q.vcr, st_q.rx[7:0], VCR_RSVD_MASK);
                        st_d.wel = 1'b0;
                    end
                    OP_WREV:
                    begin
                        st_d.evcr = keep_rsvd(st_q.evcr, st_q.rx[7:0], EVCR_RSVD_MASK);
                        st_d.wel  = 1'b0;
                    end
                    OP_WREA:
                    begin
                        st_d.ear = keep_rsvd(st_q.ear, st_q.rx[7:0], EAR_RSVD_MASK);
                        st_d.wel = 1'b0;
                    end
                    default: st_d.wel = st_q.wel;
                endcase
            end
        end
        else
        begin
            case (st_q.fsm)
                FRC_OPC:
                begin
                    if (sck_rise)
                    begin
                        st_d.rx   = rx_n;
                        st_d.ibit = ib_n;
                        if (ib_n == OPC_BITS)
                        begin
                            st_d.cmd  = rx_n[7:0];
                            st_d.bidx = '0;
                            st_d.obit = '0;
                            case (rx_n[7:0])
                                OP_WREN, OP_WRDI, OP_CLFS: st_d.fsm = FRC_ARMED;
                                OP_RDSR, OP_RDFS, OP_RDNV,
                                OP_RDVC, OP_RDEV, OP_RDEA:  st_d.fsm = FRC_RDATA;
                                OP_WRSR, OP_WRNV, OP_WRVC, OP_WREV, OP_WREA:
                                    // RULE13 - latch must already be set
                                    st_d.fsm = (st_q.wel && !st_q.wip) ? FRC_WDATA : FRC_DISCARD;
                                // RULE24 - unknown opcode ignored
                                default: st_d.fsm = FRC_DISCARD;
                            endcase
                        end
                    end
                end
                FRC_WDATA:
                begin
                    if (sck_rise)
                    begin
                        st_d.rx   = rx_n;
                        st_d.ibit = ib_n;
                        // RULE14 - arm after final data bit
                        if (ib_n == ((st_q.cmd == OP_WRNV) ? BYTE2_BITS : BYTE1_BITS))
                            st_d.fsm = FRC_ARMED;
                    end
                end
                FRC_ARMED:
                begin
                    // RULE3 - clocks past opcode discard
                    // RULE15 - clocks past data discard
                    if (sck_rise)
                        st_d.fsm = FRC_DISCARD;
                end
                FRC_RDATA:
                begin
                    // Data changes on falling edges for the host's rising sample
                    if (sck_fall)
                    begin
                        bv   = (st_q.obit == 3'h0) ? rd_byte : st_q.ob;
                        ob_n = st_q.obit + lane_width(proto_sel);
                        // RULE7 - lane choice per protocol
                        case (proto_sel)
                            FRC_DUAL:
                            begin
                                st_d.dq_out = {2'b00, bv[7:6]};
                                st_d.dq_oe  = 4'h3;
                                st_d.ob     = {bv[5:0], 2'b00};
                            end
                            FRC_QUAD:
                            begin
                                st_d.dq_out = bv[7:4];
                                st_d.dq_oe  = 4'hf;
                                st_d.ob     = {bv[3:0], 4'h0};
                            end
                            default:
                            begin
                                st_d.dq_out = {2'b00, bv[7], 1'b0};
                                st_d.dq_oe  = 4'h2;
                                st_d.ob     = {bv[6:0], 1'b0};
                            end
                        endcase
                        st_d.obit = ob_n;
                        if (ob_n == 3'h0 && st_q.bidx != 2'h2)
                            st_d.bidx = st_q.bidx + 2'h1;
                    end
                end
                default: st_d.fsm = st_q.fsm;
            endcase
        end

        // RULE19 - end clears busy and latch
        if (tmr_done)
        begin
            st_d.wip = 1'b0;
            // A same-cycle write enable must not be lost
            if (!(exec && st_q.cmd == OP_WREN))
                st_d.wel = 1'b0;
            if (st_q.pend_ok)
            begin
                if (st_q.pend_nv)
                    st_d.nvcr = st_q.pend_dat;
                else
                    // RULE17 - only bits 7:2 stored
                    st_d.status = st_q.pend_dat[7:2];
            end
        end

        // Array events last so a set beats a same-cycle clear
        if (prog_fail_evt)
            st_d.flag[FS_PROG_BIT] = 1'b1;
        if (erase_fail_evt)
            st_d.flag[FS_ERASE_BIT] = 1'b1;
        // RULE22 - protection error flags and latch
        if (prot_fail_evt)
        begin
            st_d.flag[FS_PROT_BIT] = 1'b1;
            st_d.flag[FS_PROG_BIT] = 1'b1;
            st_d.wel               = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q        <= '0;
            st_q.fsm    <= FRC_IDLE;
            st_q.status <= SR_RESET;
            st_q.flag   <= FLAG_RESET;
            st_q.nvcr   <= NVCR_RESET;
            st_q.vcr    <= VCR_RESET;
            st_q.evcr   <= EVCR_RESET;
            st_q.ear    <= EAR_RESET;
        end
        else
            st_q <= st_d;
    end

    assign dq_out      = st_q.dq_out;
    assign dq_oe       = st_q.dq_oe;
    assign wel         = st_q.wel;
    assign wip         = st_q.wip;
    assign regs.status = {st_q.status, st_q.wel, st_q.wip};
    assign regs.flag   = st_q.flag;
    assign regs.nvcr   = st_q.nvcr;
    assign regs.vcr    = st_q.vcr;
    assign regs.evcr   = st_q.evcr;
    assign regs.ear    = st_q.ear;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = !prog_fail_evt && !erase_fail_evt && !prot_fail_evt && !tmr_done;

    AST_WREN_SETS: assert property (exec && st_q.cmd == OP_WREN |=> wel) // RULE4
        else $error("write enable did not set latch");
    AST_WRDI_CLEARS: assert property (exec && st_q.cmd == OP_WRDI && !st_q.flag[FS_PROT_BIT] && quiet
                                      |=> !wel) // RULE5
        else $error("write disable did not clear latch");
    AST_WRDI_PROT_KEEPS: assert property (exec && st_q.cmd == OP_WRDI && st_q.flag[FS_PROT_BIT]
                                          |=> wel == $past(wel)) // RULE6
        else $error("write disable changed latch under protection error");
    AST_ARMED_ABORT: assert property (st_q.fsm == FRC_ARMED && !cs_n_s && sck_rise
                                      |=> st_q.fsm == FRC_DISCARD) // RULE3
        else $error("extra clock did not discard command");
    AST_DISCARD_NOEXEC: assert property (st_q.fsm == FRC_DISCARD && cs_n_s && quiet
                                         |=> $stable(wel) && $stable(st_q.vcr) && !st_q.tmr_start) // RULE15
        else $error("discarded command took effect");
    AST_CLFS_CLEARS: assert property (exec && st_q.cmd == OP_CLFS && quiet
                                      |=> regs.flag[FS_PROT_BIT] == 1'b0 && regs.flag[FS_PROG_BIT] == 1'b0
                                          && regs.flag[FS_ERASE_BIT] == 1'b0 && !wel) // RULE23
        else $error("clear flag did not clear errors");
    AST_PROT_EVT: assert property (prot_fail_evt |=> regs.flag[FS_PROT_BIT] && regs.flag[FS_PROG_BIT] && wel) // RULE22
        else $error("protection event flags wrong");
    AST_TIMED_BUSY: assert property (exec && st_q.cmd == OP_WRSR |=> wip ##1 (wip && !tmr_done)[*3]) // RULE16
        else $error("status write not busy");
    AST_TIMED_END: assert property (tmr_done && !prot_fail_evt |=> !wip && !wel) // RULE19
        else $error("timed write end did not clear busy and latch");
    AST_SR_UPDATE: assert property (tmr_done && st_q.pend_ok && !st_q.pend_nv
                                    |=> regs.status[7:2] == $past(st_q.pend_dat[7:2])) // RULE17
        else $error("status write stored wrong bits");
    AST_IDLE_NO_DRIVE: assert property (st_q.fsm == FRC_IDLE |-> dq_oe == 4'h0) // RULE8
        else $error("lanes driven outside a read");
    AST_EXT_LANE1: assert property (st_q.fsm == FRC_RDATA && proto_sel == FRC_EXT
                                    |-> dq_oe == 4'h0 || dq_oe == 4'h2) // RULE7
        else $error("extended read used wrong lane");

    COV_WREN: cover property (exec && st_q.cmd == OP_WREN);
    COV_NV_ZEROS: cover property (st_q.fsm == FRC_RDATA && st_q.cmd == OP_RDNV && st_q.bidx == 2'h2);
    COV_SR_DONE: cover property (tmr_done && !st_q.pend_nv && st_q.pend_ok);
    COV_DISCARD: cover property (st_q.fsm == FRC_ARMED ##1 st_q.fsm == FRC_DISCARD);
endmodule // frc_cmd

// File: frc_host.sv
// Behavioural SPI host that drives the register command handler
`timescale 1ns/1ps
module frc_host
    import frc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [3:0] dq_out,
    output logic            sck,
    output logic            cs_n,
    output logic      [3:0] dq_in
);
    logic [23:0] rdv;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        dq_in = 4'h0;
    end
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask
    // select held nb+nr bits, MSB first
    task automatic xfer(input int w, input logic [23:0] tx, input int nb, input int nr);
        cs_n = 1'b0;
        rdv = 24'h0;
        for (int i = 0; i < nb + nr; i += w)
        begin
            half();
            dq_in = ~dq_in;
            for (int k = 0; k < w; k++)
                if (i < nb) dq_in[w-1-k] = tx[23-i-k];
                else rdv = {rdv[22:0], dq_out[w == 1 ? 1 : w-1-k]};
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // Idle lanes toggle, stale data never looks valid
        dq_in = ~dq_in;
        repeat (8) @(negedge core_clk);
    endtask
endmodule // frc_host

// File: testbench.sv
// Testbench: host model, reference registers and comparisons
`timescale 1ns/1ps
module testbench
    import frc_pkg::*;
();
    logic core_clk, rst_n, sck, cs_n, wp_n, array_busy, prog_fail_evt, erase_fail_evt, prot_fail_evt;
    logic wel, wip, we;
    logic [3:0]  dq_in, dq_out, dq_oe;
    frc_proto_t  proto_sel;
    frc_regs_t   regs;
    logic [7:0]  st, fl, vr [3];
    logic [15:0] nv;
    logic [31:0] d, p;
    int          errors, n_checks, cyc;
    localparam logic [7:0] WOP [3] = '{OP_WRVC, OP_WREV, OP_WREA};
    localparam logic [7:0] ROP [3] = '{OP_RDVC, OP_RDEV, OP_RDEA};
    localparam logic [7:0] MSK [3] = '{VCR_RSVD_MASK, EVCR_RSVD_MASK, EAR_RSVD_MASK};
    always #25 core_clk = ~core_clk;
    frc_cmd #(.TW_CYCLES(40), .NONVOLATILE_CONFIG_WRITE_TIME_CYCLES(60)) u_frc_cmd (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
        .cs_n(cs_n), .dq_in(dq_in), .wp_n(wp_n), .proto_sel(proto_sel), .array_busy(array_busy),
        .prog_fail_evt(prog_fail_evt), .erase_fail_evt(erase_fail_evt), .prot_fail_evt(prot_fail_evt),
        .dq_out(dq_out), .dq_oe(dq_oe), .wel(wel), .wip(wip), .regs(regs));
    frc_host u_frc_host (.core_clk(core_clk), .dq_out(dq_out), .sck(sck), .cs_n(cs_n), .dq_in(dq_in));
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp();
        chk({regs.status[7:2], wel, wip, regs.flag, regs.nvcr, regs.vcr, regs.evcr, regs.ear},
            {st[7:2], we, 1'b0, fl, nv, vr[0], vr[1], vr[2]});
    endtask
    task automatic op(input logic [7:0] c, input logic [15:0] dd, input int nb, input int nr);
        p = $urandom % 3;
        proto_sel = frc_proto_t'(p[1:0]);
        u_frc_host.xfer(1 << p, {c, dd}, nb, nr);
    endtask
    // Bounded wait for the self-timed write
    task automatic settle();
        for (int i = 0; i < 200 && wip !== 1'b0; i++) @(negedge core_clk);
        we = 1'b0;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            print_verdict();
        end
    end
    initial
    begin
        {core_clk, rst_n, array_busy, prog_fail_evt, erase_fail_evt, prot_fail_evt, we} = 7'h00;
        wp_n = 1'b1;
        proto_sel = FRC_EXT;
        void'($urandom(32'hf2dc));
        {st, fl, nv, vr[0], vr[1], vr[2]} = {16'h0000, 16'hffff, 24'h000000};
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        cmp();
        op(OP_WREN, 0, 8, 0);
        we = 1'b1;
        cmp();
        op(OP_WRDI, 0, 16, 0);
        cmp();
        op(8'h3c, 0, 8, 0);
        cmp();
        op(OP_WREN, 0, 8, 0);
        op(OP_WRVC, 16'h5a00, 24, 0);
        cmp();
        op(OP_WRDI, 0, 8, 0);
        we = 1'b0;
        cmp();
        op(OP_WRVC, 16'ha500, 16, 0);
        cmp();
        for (int j = 0; j < 3; j++)
        begin
            d = $urandom;
            op(OP_WREN, 0, 8, 0);
            op(WOP[j], {d[7:0], 8'h00}, 16, 0);
            vr[j] = (d[7:0] & ~MSK[j]) | (vr[j] & MSK[j]);
            we = 1'b0;
            cmp();
            op(ROP[j], 0, 8, 16);
            chk({40'h0, u_frc_host.rdv}, {48'h0, vr[j], vr[j]});
        end
        d = $urandom | 32'h80;
        op(OP_WREN, 0, 8, 0);
        op(OP_WRSR, {d[7:0], 8'h00}, 16, 0);
        chk({63'h0, wip}, 64'h1);
        settle();
        st[7:2] = d[7:2];
        cmp();
        op(OP_RDSR, 0, 8, 16);
        chk({40'h0, u_frc_host.rdv}, {48'h0, st[7:2], 2'b00, st[7:2], 2'b00});
        wp_n = 1'b0;
        op(OP_WREN, 0, 8, 0);
        op(OP_WRSR, {~d[7:0], 8'h00}, 16, 0);
        settle();
        cmp();
        wp_n = 1'b1;
        d = $urandom | 32'h10;
        op(OP_WREN, 0, 8, 0);
        op(OP_WRNV, {d[7:0], d[15:8]}, 24, 0);
        chk({63'h0, wip}, 64'h1);
        settle();
        nv = d[15:0];
        cmp();
        op(OP_RDNV, 0, 8, 24);
        chk({40'h0, u_frc_host.rdv}, {40'h0, d[7:0], d[15:8], 8'h00});
        @(negedge core_clk) prot_fail_evt = 1'b1;
        @(negedge core_clk) prot_fail_evt = 1'b0;
        {fl, we} = {8'h12, 1'b1};
        cmp();
        op(OP_RDFS, 0, 8, 8);
        chk({40'h0, u_frc_host.rdv}, 64'h92);
        op(OP_WRDI, 0, 8, 0);
        cmp();
        op(OP_CLFS, 0, 8, 0);
        {fl, we} = 9'h000;
        cmp();
        op(OP_RDSR, 0, 8, 4);
        chk({60'h0, dq_oe}, 64'h0);
        print_verdict();
    end
endmodule // testbench
